// >>> apfbc_control.sv
// Top of the amplifier power, fault, boot and input-select control block
//
// Summary of operation
// [R1] PLL enable pin low enables PLL with bus ratio; high bypasses it.
// [R2] Bypassed PLL uses fixed ratio 1024x, 512x, 256x per sample-rate group.
// [R3] Host supplies exact master clock in bypass, else must enable the PLL.
// [R4] Carrier clock is master clock divided by 128 bypassed, 32 with PLL.
// [R5] Reset clears stored data and restores all defaults.
// [R6] Reset state is left on the 256th cycle after reset release.
// [R7] Power-down fades volume out, then stops stages, clocks and bias.
// [R8] Whole power-down sequence ends within 510 frame clocks.
// [R9] Powered down, bus writes are ignored and register contents kept.
// [R10] Power-down released mid fade runs fade-in and restores operation.
// [R11] Default volume pin high gives +1.675dB, low gives mute.
// [R12] Over-temperature disables power stages until the temperature recovers.
// [R13] Over-current or over-temperature disables outputs and latches fault low.
// [R14] Latched fault clears only by reset, power-down or master mute after cause ends.
// [R15] Supply below 2.7V stops stages and processing until above 2.8V.
// [R16] Master clock still 500 ns or more flags stop and forces weak low.
// [R17] Clock return after stop latches fault until reset, power-down or mute.
// [R18] Host drives power-down low before stopping any clock.
// [R19] Boot pin high at init loads 371 EEPROM bytes as master, then slave.
// [R20] First 256 bytes from device 101000, remaining 115 from 101001.
// [R21] Input select low takes serial input a, high takes input b.
// [R22] Host mutes over the bus before changing input select.
// [R23] Fade-out steps volume down equally once per frame clock.
`timescale 1ns/1ps
module apfbc_control
  import apfbc_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          clk_en,
  input  wire logic          pll_enable_n,
  input  wire logic [3:0]    clock_ratio_field,
  input  wire apfbc_fs_t     fs_group,
  input  wire logic          master_clk_sample,
  input  wire logic          frame_clk_in,
  input  wire logic          power_down_n,
  input  wire logic          default_volume_select,
  input  wire logic          boot_source_select,
  input  wire logic          input_source_select,
  input  wire logic          serial_audio_in_a,
  input  wire logic          serial_audio_in_b,
  input  wire apfbc_sense_t  sense,
  input  wire logic          master_mute,
  input  wire logic          bus_write,
  input  wire logic [7:0]    bus_wdata,
  input  wire logic          boot_byte_valid,
  input  wire logic [7:0]    boot_byte,
  output logic               reset_done,
  output logic               pll_enabled,
  output logic [3:0]         clock_ratio,
  output logic [10:0]        bypass_ratio,
  output logic               carrier_tick,
  output logic [7:0]         volume,
  output logic [7:0]         volume_setting,
  output apfbc_power_t       power,
  output logic               powered_down,
  output logic               fault_o,
  output logic               fault_oe,
  output logic               clock_stopped,
  output apfbc_boot_req_t    boot_req,
  output logic               boot_busy,
  output logic [7:0]         boot_last_byte,
  output logic               bus_slave,
  output logic               serial_audio
);
  typedef enum logic [2:0] {APFBC_RUN, APFBC_FADE_OUT, APFBC_SHUTDOWN, APFBC_DOWN, APFBC_FADE_IN} apfbc_pd_state_t;

  apfbc_pd_state_t pd_state;
  logic [8:0]      exit_count;
  logic            frame_d;
  logic            frame_rise;
  logic [6:0]      still_count;
  logic            mclk_d;
  logic            mclk_edge;
  logic            fault_latched;
  logic            supply_halt;
  logic            thermal_off;
  logic            carrier_raw;
  logic [8:0]      boot_count;
  logic            boot_armed;
  logic            active;

  assign frame_rise = frame_clk_in & ~frame_d;
  assign mclk_edge  = master_clk_sample ^ mclk_d;
  assign active     = reset_done && !supply_halt;

  apfbc_clock_divider u_divider
  (
    .clk          (clk),
    .reset        (reset),
    .clk_en       (clk_en & reset_done),
    .pll_enable   (~pll_enable_n),
    .carrier_tick (carrier_raw)
  );

  // Reset exit counter, release on the 256th cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset) // [R5]
    begin
      exit_count <= 9'h000;
      reset_done <= 1'b0;
    end
    else if (clk_en && !reset_done)
    begin
      exit_count <= exit_count + 9'h001;
      reset_done <= (exit_count == 9'(RESET_EXIT_CYCLES - 1)); // [R6]
    end
  end

  // Clock configuration
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pll_enabled  <= 1'b0;
      clock_ratio  <= CLOCK_RATIO_RESET;
      bypass_ratio <= RATIO_48K_GROUP;
      carrier_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      pll_enabled  <= ~pll_enable_n; // [R1]
      carrier_tick <= carrier_raw;
      if (!pll_enable_n && pd_state == APFBC_RUN && bus_write)
        clock_ratio <= clock_ratio_field; // [R1] [R9]
      case (fs_group) // [R2]
        APFBC_FS_48K:  bypass_ratio <= RATIO_48K_GROUP;
        APFBC_FS_96K:  bypass_ratio <= RATIO_96K_GROUP;
        default:       bypass_ratio <= RATIO_192K_GROUP;
      endcase
    end
  end

  // Edge trackers and master clock stop detection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      frame_d       <= 1'b0;
      mclk_d        <= 1'b0;
      still_count   <= 7'h00;
      clock_stopped <= 1'b0;
    end
    else if (clk_en)
    begin
      frame_d <= frame_clk_in;
      mclk_d  <= master_clk_sample;
      if (mclk_edge)
      begin
        still_count   <= 7'h00;
        clock_stopped <= 1'b0;
      end
      else if (still_count < 7'(CLK_STOP_CYCLES - 1))
        still_count <= still_count + 7'h01;
      else
        clock_stopped <= 1'b1; // [R16]
    end
  end

  // Supply hysteresis and thermal flag follow, thresholds held by the analog comparators
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      supply_halt <= 1'b0;
      thermal_off <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sense.supply_low)
        supply_halt <= 1'b1; // [R15]
      else if (sense.supply_ok)
        supply_halt <= 1'b0; // [R15]
      thermal_off <= sense.over_temp; // [R12]
    end
  end

  // Fault latch; a new cause wins over a power-down or mute clear in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset) // [R14]
      fault_latched <= 1'b0;
    else if (clk_en)
    begin
      if (sense.over_temp || sense.over_current || (clock_stopped && mclk_edge))
        fault_latched <= 1'b1; // [R13] [R17]
      else if (!power_down_n || master_mute)
        fault_latched <= 1'b0; // [R14] [R17]
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fault_o  <= 1'b0;
      fault_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      fault_o  <= 1'b0;
      fault_oe <= fault_latched; // [R13]
    end
  end

  // Power-down sequencer, one volume step per frame clock
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pd_state       <= APFBC_RUN;
      volume_setting <= VOL_MUTED;
      volume         <= VOL_MUTED;
    end
    else if (clk_en)
    begin
      if (!reset_done)
        volume_setting <= default_volume_select ? VOL_DEFAULT_HIGH : VOL_MUTED; // [R11]
      else if (bus_write && pd_state != APFBC_DOWN)
        volume_setting <= bus_wdata; // [R9]
      case (pd_state)
        APFBC_RUN:
        begin
          volume <= reset_done ? volume_setting : VOL_MUTED;
          if (reset_done && !power_down_n)
            pd_state <= APFBC_FADE_OUT; // [R7]
        end
        APFBC_FADE_OUT:
          if (power_down_n)
            pd_state <= APFBC_FADE_IN; // [R10]
          else if (volume == VOL_MUTED)
            pd_state <= APFBC_SHUTDOWN; // [R7]
          else if (frame_rise)
            volume <= volume - VOL_STEP; // [R23] [R8]
        APFBC_SHUTDOWN:
          pd_state <= APFBC_DOWN; // [R7]
        APFBC_DOWN:
          if (power_down_n)
            pd_state <= APFBC_FADE_IN;
        APFBC_FADE_IN:
          if (!power_down_n)
            pd_state <= APFBC_FADE_OUT; // [R7]
          else if (volume >= volume_setting)
          begin
            volume   <= volume_setting;
            pd_state <= APFBC_RUN; // [R10]
          end
          else if (frame_rise)
            volume <= volume + VOL_STEP;
        default:
          pd_state <= APFBC_RUN;
      endcase
    end
  end

  // Power outputs follow sequencer and protections
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      power        <= '0;
      powered_down <= 1'b0;
    end
    else if (clk_en)
    begin
      powered_down        <= (pd_state == APFBC_DOWN); // [R9]
      power.clocks_fed    <= (pd_state != APFBC_DOWN && pd_state != APFBC_SHUTDOWN); // [R7] [R10]
      power.bias_on       <= (pd_state != APFBC_DOWN); // [R7]
      power.processing_on <= active && pd_state != APFBC_DOWN; // [R15]
      power.stages_on     <= active && !thermal_off && !fault_latched && !clock_stopped &&
                             (pd_state == APFBC_RUN || pd_state == APFBC_FADE_OUT ||
                              pd_state == APFBC_FADE_IN); // [R12] [R13] [R15]
      power.weak_low      <= clock_stopped; // [R16]
    end
  end

  // Boot loader request sequencer; byte source strap caught after reset
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      boot_armed     <= 1'b1;
      boot_busy      <= 1'b0;
      boot_count     <= BOOT_ADDR_RESET;
      boot_req       <= '0;
      boot_last_byte <= 8'h00;
      bus_slave      <= 1'b0;
    end
    else if (clk_en)
    begin
      if (boot_armed && reset_done)
      begin
        boot_armed <= 1'b0;
        boot_busy  <= boot_source_select; // [R19]
        bus_slave  <= !boot_source_select; // [R19]
      end
      else if (boot_busy)
      begin
        boot_req.req        <= 1'b1;
        boot_req.byte_index <= boot_count;
        boot_req.dev_addr   <= (boot_count < 9'(BOOT_PAGE0_BYTES)) ?
                               EEPROM_ADDR_PAGE0 : EEPROM_ADDR_PAGE1; // [R20]
        if (boot_byte_valid)
        begin
          boot_last_byte <= boot_byte;
          boot_count     <= boot_count + 9'h001;
          if (boot_count == 9'(BOOT_BYTES - 1))
          begin
            boot_busy    <= 1'b0;
            boot_req.req <= 1'b0;
            bus_slave    <= 1'b1; // [R19]
          end
        end
      end
    end
  end

  // Serial input selection
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      serial_audio <= 1'b0;
    else if (clk_en)
      serial_audio <= input_source_select ? serial_audio_in_b : serial_audio_in_a; // [R21]
  end
endmodule : apfbc_control

// >>> apfbc_pkg.sv
// Constants and carrier types for the amplifier power, fault and boot control block
package apfbc_pkg;
  localparam int unsigned CLK_HZ            = 125000000;
  localparam int unsigned RESET_EXIT_CYCLES = 256;
  localparam int unsigned PD_LIMIT_FRAMES   = 510;
  localparam int unsigned CLK_STOP_NS       = 500;
  localparam int unsigned CLK_STOP_CYCLES   = (CLK_STOP_NS * (CLK_HZ / 1000000)) / 1000;
  localparam int unsigned DIV_BYPASS        = 128;
  localparam int unsigned DIV_PLL           = 32;
  localparam int unsigned BOOT_BYTES        = 371;
  localparam int unsigned BOOT_PAGE0_BYTES  = 256;
  localparam logic [5:0]  EEPROM_ADDR_PAGE0 = 6'h28;
  localparam logic [5:0]  EEPROM_ADDR_PAGE1 = 6'h29;
  localparam logic [7:0]  VOL_MAX           = 8'hff;
  localparam logic [7:0]  VOL_DEFAULT_HIGH  = 8'hf0;
  localparam logic [7:0]  VOL_MUTED         = 8'h00;
  localparam logic [7:0]  VOL_STEP          = 8'h01;
  localparam logic [10:0] RATIO_48K_GROUP   = 11'h400;
  localparam logic [10:0] RATIO_96K_GROUP   = 11'h200;
  localparam logic [10:0] RATIO_192K_GROUP  = 11'h100;
  localparam logic [3:0]  CLOCK_RATIO_RESET = 4'h4;
  localparam logic [8:0]  BOOT_ADDR_RESET   = 9'h000;

  typedef enum logic [1:0] {APFBC_FS_48K, APFBC_FS_96K, APFBC_FS_192K, APFBC_FS_192K_ALT} apfbc_fs_t;

  typedef struct packed {
    logic over_temp;
    logic over_current;
    logic supply_low;
    logic supply_ok;
  } apfbc_sense_t;

  typedef struct packed {
    logic       stages_on;
    logic       clocks_fed;
    logic       bias_on;
    logic       processing_on;
    logic       weak_low;
  } apfbc_power_t;

  typedef struct packed {
    logic       req;
    logic [5:0] dev_addr;
    logic [8:0] byte_index;
  } apfbc_boot_req_t;
endpackage : apfbc_pkg

// >>> apfbc_clock_divider.sv
// Carrier clock enable generator, divide by 128 bypassed or 32 with PLL
`timescale 1ns/1ps
module apfbc_clock_divider
  import apfbc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic clk_en,
  input  wire logic pll_enable,
  output logic      carrier_tick
);
  logic [6:0] count;
  logic [6:0] limit;

  assign limit = pll_enable ? 7'(DIV_PLL - 1) : 7'(DIV_BYPASS - 1); // [R4]

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count        <= 7'h00;
      carrier_tick <= 1'b0;
    end
    else if (clk_en)
    begin
      carrier_tick <= (count >= limit);
      count        <= (count >= limit) ? 7'h00 : count + 7'h01; // [R4]
    end
  end
endmodule : apfbc_clock_divider

// >>> apfbc_control_props.sv
// Port-level checks for the power, fault and boot control block
`timescale 1ns/1ps
module apfbc_control_props
  import apfbc_pkg::*;
(
  input wire logic            clk,
  input wire logic            reset,
  input wire logic            pll_enable_n,
  input wire logic            power_down_n,
  input wire logic            master_mute,
  input wire apfbc_sense_t    sense,
  input wire logic            reset_done,
  input wire logic            pll_enabled,
  input wire logic [7:0]      volume,
  input wire apfbc_power_t    power,
  input wire logic            fault_oe,
  input wire apfbc_boot_req_t boot_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [8:0] since_rel;
  always_ff @(posedge clk or posedge reset)
    if (reset)
      since_rel <= 9'h000;
    else if (!reset_done)
      since_rel <= since_rel + 9'h001;
  chk_exit_count: assert property ($rose(reset_done) |-> since_rel == 9'h100)
    else $error("reset exit count");
  chk_pll_follow: assert property (!pll_enable_n |=> pll_enabled)
    else $error("pll not enabled");
  chk_fault_set: assert property (sense.over_current |-> ##[1:2] fault_oe)
    else $error("fault not raised");
  chk_fault_hold: assert property (fault_oe && power_down_n && !master_mute && $past(power_down_n) &&
    !$past(master_mute) |=> fault_oe) else $error("fault dropped");
  chk_hot_off: assert property (sense.over_temp |-> ##[1:2] !power.stages_on)
    else $error("stages on while hot");
  chk_supply_off: assert property (sense.supply_low |-> ##[1:2] !power.processing_on)
    else $error("processing on at low supply");
  chk_fade_down: assert property (!power_down_n && !$past(power_down_n) && !$past(power_down_n, 2)
    |=> volume <= $past(volume)) else $error("volume rose in fade-out");
  chk_boot_page: assert property (boot_req.req |-> boot_req.dev_addr ==
    (boot_req.byte_index < 9'h100 ? EEPROM_ADDR_PAGE0 : EEPROM_ADDR_PAGE1)) else $error("boot page");
endmodule : apfbc_control_props

bind apfbc_control apfbc_control_props u_props (.clk, .reset, .pll_enable_n, .power_down_n, .master_mute,
  .sense, .reset_done, .pll_enabled, .volume, .power, .fault_oe, .boot_req);

// >>> apfbc_eeprom_model.sv
// Serial EEPROM stand-in answering boot byte fetches, fast or slow
`timescale 1ns/1ps
module apfbc_eeprom_model
  import apfbc_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            reset,
  input  wire logic            slow,
  input  wire apfbc_boot_req_t boot_req,
  output logic                 boot_byte_valid,
  output logic [7:0]           boot_byte
);
  logic [2:0] wait_cnt;
  // One-cycle valid, then a gap so the index can move on
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      wait_cnt        <= 3'h0;
      boot_byte_valid <= 1'b0;
      boot_byte       <= 8'h00;
    end
    else
    begin
      boot_byte_valid <= 1'b0;
      // Released line never holds the old byte
      boot_byte       <= ~boot_byte;
      if (!boot_req.req || boot_byte_valid)
        wait_cnt <= 3'h0;
      else if (wait_cnt == (slow ? 3'h5 : 3'h1))
      begin
        boot_byte_valid <= 1'b1;
        boot_byte       <= boot_req.byte_index[7:0] ^ {2'b00, boot_req.dev_addr};
      end
      else
        wait_cnt <= wait_cnt + 3'h1;
    end
endmodule : apfbc_eeprom_model

// >>> tb_apfbc_control.sv
// Self-checking bench for the power, fault and boot control block
`timescale 1ns/1ps
module tb_apfbc_control
  import apfbc_pkg::*;
;
  logic            clk = 0, reset = 1, pll_enable_n = 1, master_clk_sample = 0, power_down_n = 1, mclk_run = 1;
  logic            master_mute = 0, bus_write = 0, input_source_select = 0, serial_audio_in_a = 0;
  logic            serial_audio_in_b = 0, reset_done, pll_enabled, carrier_tick, powered_down, fault_oe;
  logic            clock_stopped, boot_busy, bus_slave, serial_audio, boot_byte_valid, frame_clk_in, fault_line;
  logic            fault_o, default_volume_select = 1, boot_source_select = 1;
  logic [3:0]      clock_ratio_field = 4'h0, clock_ratio;
  logic [7:0]      bus_wdata = 8'h00, boot_byte, boot_last_byte, volume, volume_setting, v;
  logic [6:0]      fcnt = 7'h00;
  logic [10:0]     bypass_ratio;
  logic [2:0]      r;
  apfbc_fs_t       fs_group = APFBC_FS_48K;
  apfbc_sense_t    sense = 4'h1;
  apfbc_power_t    power;
  apfbc_boot_req_t boot_req;
  int              mismatches = 0, checks_done = 0, seed = 31, n, nbytes = 0;

  apfbc_control uut (.clk, .reset, .clk_en(1'b1), .pll_enable_n, .clock_ratio_field, .fs_group, .master_clk_sample,
    .frame_clk_in, .power_down_n, .default_volume_select, .boot_source_select, .input_source_select,
    .serial_audio_in_a, .serial_audio_in_b, .sense, .master_mute, .bus_write, .bus_wdata, .boot_byte_valid,
    .boot_byte, .reset_done, .pll_enabled, .clock_ratio, .bypass_ratio, .carrier_tick, .volume, .volume_setting,
    .power, .powered_down, .fault_o, .fault_oe, .clock_stopped, .boot_req, .boot_busy, .boot_last_byte,
    .bus_slave, .serial_audio);
  apfbc_eeprom_model eeprom (.clk, .reset, .slow(fcnt[6]), .boot_req, .boot_byte_valid, .boot_byte);

  // Open-drain fault pin with pull-up
  assign fault_line = fault_oe ? fault_o : 1'b1;
  assign frame_clk_in = fcnt[2];
  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    fcnt <= fcnt + 7'h01;
    if (mclk_run)
      master_clk_sample <= ~master_clk_sample;
    if (boot_byte_valid)
      nbytes <= nbytes + 1;
  end

  task automatic give_verdict();
    if (mismatches == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc

  // Values are read at the edge, before that edge's updates land
  task automatic wait_hi(ref logic s, input int lim, output int k);
    k = 0;
    while (s !== 1'b1)
    begin
      @(posedge clk);
      k++;
      if (k > lim)
      begin
        mismatches++;
        give_verdict();
      end
    end
  endtask : wait_hi

  task automatic gap(output int k);
    wait_hi(carrier_tick, 300, k);
    @(posedge clk);
    wait_hi(carrier_tick, 300, k);
    k++;
  endtask : gap

  task automatic wr(input logic [7:0] d);
    bus_wdata <= d;
    bus_write <= 1'b1;
    cyc(1);
    bus_write <= 1'b0;
  endtask : wr

  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    chk(clock_ratio, CLOCK_RATIO_RESET);
    chk(bypass_ratio, RATIO_48K_GROUP);
    wait_hi(reset_done, 300, n);
    chk(16'(n), 16'(RESET_EXIT_CYCLES + 1));
    chk(volume_setting, VOL_DEFAULT_HIGH);
    wait_hi(bus_slave, 4000, n);
    chk(16'(nbytes), 16'(BOOT_BYTES));
    chk(boot_last_byte, 8'h72 ^ {2'b00, EEPROM_ADDR_PAGE1});
    for (int g = 0; g < 3; g++)
    begin
      fs_group <= apfbc_fs_t'(g);
      cyc(2);
      chk(bypass_ratio, RATIO_48K_GROUP >> g);
    end
    for (int p = 1; p >= 0; p--)
    begin
      r = 3'($random(seed));
      pll_enable_n <= p[0];
      cyc(2);
      clock_ratio_field <= {1'b0, r};
      wr({5'h08, r});
      cyc(2);
      chk(pll_enabled, !p[0]);
      chk(clock_ratio, p[0] ? CLOCK_RATIO_RESET : {1'b0, r});
      gap(n);
      gap(n);
      chk(16'(n), p[0] ? 16'(DIV_BYPASS) : 16'(DIV_PLL));
    end
    master_mute <= 1'b1;
    cyc(1);
    repeat (16)
    begin
      r = 3'($random(seed));
      {input_source_select, serial_audio_in_a, serial_audio_in_b} <= r;
      cyc(2);
      chk(serial_audio, r[2] ? r[0] : r[1]);
    end
    master_mute <= 1'b0;
    sense.over_current <= 1'b1;
    cyc(1);
    sense.over_current <= 1'b0;
    cyc(6);
    chk(fault_line, 1'b0);
    master_mute <= 1'b1;
    cyc(3);
    chk(fault_line, 1'b1);
    sense.over_temp <= 1'b1;
    cyc(3);
    chk(power.stages_on, 1'b0);
    sense <= 4'h2;
    cyc(4);
    chk({power.stages_on, power.processing_on}, 2'h0);
    sense <= 4'h1;
    cyc(3);
    chk({power.stages_on, power.processing_on}, 2'h3);
    master_mute <= 1'b0;
    mclk_run <= 1'b0;
    wait_hi(clock_stopped, 100, n);
    cyc(1);
    chk(power.weak_low, 1'b1);
    mclk_run <= 1'b1;
    cyc(4);
    chk(fault_line, 1'b0);
    power_down_n <= 1'b0;
    cyc(40);
    chk(fault_line, 1'b1);
    v = volume;
    power_down_n <= 1'b1;
    cyc(80);
    chk({volume > v, power.stages_on}, 2'h3);
    wr(8'hff);
    power_down_n <= 1'b0;
    wait_hi(powered_down, 4200, n);
    chk(n <= PD_LIMIT_FRAMES * 8, 1'b1);
    chk({power.stages_on, power.clocks_fed, power.bias_on, volume}, 11'h000);
    v = volume_setting;
    wr(~v);
    cyc(3);
    chk(volume_setting, v);
    // Clock stopped only after power-down, so no fault is left latched
    mclk_run <= 1'b0;
    wait_hi(clock_stopped, 100, n);
    mclk_run <= 1'b1;
    cyc(5);
    chk(fault_line, 1'b1);
    {default_volume_select, boot_source_select, power_down_n} <= 3'h1;
    reset <= 1'b1;
    cyc(2);
    reset <= 1'b0;
    wait_hi(reset_done, 300, n);
    chk(16'(n), 16'(RESET_EXIT_CYCLES + 1));
    chk(volume_setting, VOL_MUTED);
    cyc(2);
    chk({bus_slave, boot_busy}, 2'h2);
    give_verdict();
  end
endmodule : tb_apfbc_control
